//--- design/supply_monitor_pkg.sv
// Purpose: shared constants and types of the supply monitor control block
// Assumes: 16-bit register port with byte offsets, 20 MHz system clock
// Notes:   register state and output groups travel as packed structs
package supply_monitor_pkg;

  // register offsets on the plain register port
  localparam logic [3:0] OFS_CLOCK_CTRL  = 4'h0;
  localparam logic [3:0] OFS_CTRL        = 4'h2;
  localparam logic [3:0] OFS_FLAG        = 4'h4;
  localparam logic [3:0] OFS_IRQ_ENABLE  = 4'h6;
  localparam logic [3:0] OFS_PROTECT     = 4'h8;

  // protection key and special field codes
  localparam logic [15:0] PROTECT_KEY    = 16'h0096;
  localparam logic [3:0]  RESET_SEL_CODE = 4'hA;
  localparam logic [1:0]  MODE_CONT      = 2'h0;
  localparam logic [4:0]  LEVEL_BAD_LOW  = 5'h00;
  localparam logic [4:0]  LEVEL_BAD_HIGH = 5'h1F;

  // intermittent period, last tick index for /128, /256, /512
  localparam logic [8:0] PER_LAST_128 = 9'h07F;
  localparam logic [8:0] PER_LAST_256 = 9'h0FF;
  localparam logic [8:0] PER_LAST_512 = 9'h1FF;

  // reset values of the register fields
  localparam logic       RST_DEBUG_RUN = 1'b1;
  localparam logic [2:0] RST_CLK_DIV   = 3'h0;
  localparam logic [1:0] RST_CLK_SRC   = 2'h0;

  // hardware reset time after disabling, in ns and in clk_sys cycles
  localparam int          CLK_PERIOD_NS = 50;
  localparam int          DISABLE_NS    = 200;
  localparam logic [2:0]  DIS_LAST      = 3'((DISABLE_NS + CLK_PERIOD_NS - 1)
                                             / CLK_PERIOD_NS - 1);

  typedef enum logic [1:0] {PH_IDLE, PH_CONT, PH_SLEEP, PH_SAMPLE} phase_t;

  typedef struct packed {
    logic       debug_run;
    logic [2:0] divider;
    logic [1:0] source;
  } clk_cfg_t;

  typedef struct packed {
    logic       power;
    logic       source_sel;
    logic [4:0] level;
  } comp_ctrl_t;

  typedef struct packed {
    logic       prot_open;
    clk_cfg_t   clk;
    logic       vsel;
    logic [1:0] low_cnt_sel;
    logic [4:0] thresh;
    logic [3:0] rst_sel;
    logic [1:0] run_mode;
    logic       enable;
    logic       flag;
    logic       ie;
    logic       result;
    logic       fired;
    logic       rst_out;
    logic       irq;
    logic       comp_on;
    logic       disabling;
    logic [2:0] dis_cnt;
    logic [2:0] cmp_s;
    logic       cmp_f;
    logic [2:0] ck_s;
    logic       ck_f;
    phase_t     phase;
    logic [8:0] per_cnt;
    logic [1:0] settle;
    logic [3:0] low_run;
    logic [15:0] rdata;
  } state_t;

endpackage : supply_monitor_pkg

//--- design/supply_voltage_detector_ctrl.sv
// Purpose: control logic of the on-chip supply voltage detector
// Assumes: analog comparator and detector clock come in asynchronously
// Notes:   register writes to clock and control need the protect key
//
// Summary of operation
// - result bit reads 1 when sensed voltage is below threshold
// - run mode 0 compares continuously and keeps updating result
// - continuous low sets flag, or issues reset when reset select is 0xA
// - run modes 1 to 3 power comparator periodically for one detection
// - intermittent period is detector clock over 128, 256 or 512
// - intermittent event needs 1, 2, 4 or 8 consecutive low detections
// - low count ignored in continuous mode; writes only when mode nonzero
// - interrupt request only while flag and enable set; write 1 clears
// - flag stays set after supply recovers until software clears it
// - reset select 0xA chooses reset, any other value interrupt
// - reset asserts at the moment the flag would otherwise be set
// - after reset detector runs continuous and keeps its sensed source
// - reset held until result returns to 0, then released
// - reset state reverts clock fields, clears low count, mode, irq enable
// - debug run bit keeps detector clock running in debug mode
// - clock source and divider codes are stored for the clock generator
// - threshold selects 30 levels; codes 0x00 and 0x1F are refused
// - voltage select routes external pin when 1, main supply when 0
// - disabling resets detector hardware; enable reads 0 when finished
// - changing count, reset select, mode or clearing flag reinitializes
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
module supply_voltage_detector_ctrl
  import supply_monitor_pkg::*;
#(
  parameter int SETTLE_TICKS = 2
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output      logic [15:0] reg_rdata,
  input  wire logic        detector_clock,
  input  wire logic        debug_mode,
  input  wire logic        comp_low,
  output      comp_ctrl_t  comp_ctrl,
  output      clk_cfg_t    clock_cfg,
  output      logic        irq,
  output      logic        monitor_reset
);

  if (SETTLE_TICKS < 1 || SETTLE_TICKS > 3) begin : g_chk
    $error("SETTLE_TICKS must lie between 1 and 3");
  end

  // how the block is put together:
  // - all state lives in one packed struct, filled by one combinational
  //   process and registered by one clocked process
  // - the comparator result and the detector clock are asynchronous and
  //   pass three flops; a change counts once stages two and three agree,
  //   which costs four system cycles of latency but rejects a single
  //   glitch from the analog side
  // - the detector clock is never used as a clock here; its settled rising
  //   edge becomes a one-cycle tick, so the whole block stays in one domain
  // - the period counter keeps counting through the settle ticks, so the
  //   distance between two detections is the full period in every mode
  // limitation: disabling while the reset request stands leaves the request
  // up, because release needs a continuous compare that sees recovery
  state_t s;
  state_t next_s;

  logic       wr_clk;
  logic       wr_ctl;
  logic       wr_flag;
  logic       wr_ie;
  logic       active;
  logic       tick;
  logic       reinit;
  logic       event_low;
  logic [3:0] need;
  logic [8:0] per_last;

  // bus decode; clock and control writes need the unlock key
  assign wr_clk  = reg_wr && reg_addr == OFS_CLOCK_CTRL && s.prot_open;
  assign wr_ctl  = reg_wr && reg_addr == OFS_CTRL && s.prot_open;
  assign wr_flag = reg_wr && reg_addr == OFS_FLAG;
  assign wr_ie   = reg_wr && reg_addr == OFS_IRQ_ENABLE;
  assign active  = s.enable && !s.disabling;

  // a detector tick is a settled rising edge, frozen in debug unless allowed
  assign tick = s.ck_s[1] == s.ck_s[2] && s.ck_s[2] && !s.ck_f
                && !(debug_mode && !s.clk.debug_run);

  assign need = 4'h1 << s.low_cnt_sel;

  // period length per run mode
  always_comb begin
    unique case (s.run_mode)
      2'h1:    per_last = PER_LAST_128;
      2'h2:    per_last = PER_LAST_256;
      default: per_last = PER_LAST_512;
    endcase
  end

  always_comb begin
    next_s    = s;
    reinit    = 1'b0;
    event_low = 1'b0;

    // three-stage synchronisers; a change counts once stages 2 and 3 agree
    next_s.cmp_s = {s.cmp_s[1:0], comp_low};
    next_s.ck_s  = {s.ck_s[1:0], detector_clock};
    if (s.cmp_s[1] == s.cmp_s[2]) begin
      next_s.cmp_f = s.cmp_s[2];
    end
    if (s.ck_s[1] == s.ck_s[2]) begin
      next_s.ck_f = s.ck_s[2];
    end

    // protection key register: only the exact key unlocks
    if (reg_wr && reg_addr == OFS_PROTECT) begin
      next_s.prot_open = reg_wdata == PROTECT_KEY;
    end

    if (wr_clk) begin
      next_s.clk.debug_run = reg_wdata[8];
      next_s.clk.divider   = reg_wdata[6:4];
      next_s.clk.source    = reg_wdata[1:0];
    end

    if (wr_ctl) begin
      next_s.vsel    = reg_wdata[15];
      next_s.rst_sel = reg_wdata[7:4];
      next_s.run_mode = reg_wdata[2:1];
      // prohibited threshold codes keep the previous level
      if (reg_wdata[12:8] != LEVEL_BAD_LOW && reg_wdata[12:8] != LEVEL_BAD_HIGH) begin
        next_s.thresh = reg_wdata[12:8];
      end
      // the count field only accepts writes outside continuous mode
      if (s.run_mode != MODE_CONT) begin
        next_s.low_cnt_sel = reg_wdata[14:13];
      end
      if (s.enable && (next_s.low_cnt_sel != s.low_cnt_sel
          || next_s.rst_sel != s.rst_sel || next_s.run_mode != s.run_mode)) begin
        reinit = 1'b1;
      end
      // enable: a 0 starts the hardware reset, a 1 while it runs is ignored
      if (!reg_wdata[0] && s.enable && !s.disabling) begin
        next_s.disabling = 1'b1;
        next_s.dis_cnt   = DIS_LAST;
      end else if (reg_wdata[0] && !s.enable) begin
        next_s.enable = 1'b1;
        reinit        = 1'b1;
      end
    end

    if (wr_ie) begin
      next_s.ie = reg_wdata[0];
    end

    // hardware reset of the detector; registers and flag survive
    if (s.disabling) begin
      if (s.dis_cnt == 3'h0) begin
        next_s.enable    = 1'b0;
        next_s.disabling = 1'b0;
      end else begin
        next_s.dis_cnt = s.dis_cnt - 3'h1;
      end
    end

    // detection sequencing
    if (!active) begin
      next_s.phase   = PH_IDLE;
      next_s.low_run = 4'h0;
      next_s.fired   = 1'b0;
      next_s.per_cnt = 9'h000;
    end else if (s.run_mode == MODE_CONT) begin
      next_s.phase  = PH_CONT;
      next_s.result = s.cmp_f;
      // one event per low episode; rearmed by recovery or reinit
      if (s.cmp_f && !s.fired) begin
        event_low    = 1'b1;
        next_s.fired = 1'b1;
      end else if (!s.cmp_f) begin
        next_s.fired = 1'b0;
      end
    end else begin
      if (s.phase != PH_SLEEP && s.phase != PH_SAMPLE) begin
        next_s.phase   = PH_SLEEP;
        next_s.per_cnt = 9'h000;
      end else if (tick) begin
        if (s.per_cnt == per_last) begin
          next_s.per_cnt = 9'h000;
          next_s.phase   = PH_SAMPLE;
          next_s.settle  = 2'(SETTLE_TICKS - 1);
        end else begin
          next_s.per_cnt = s.per_cnt + 9'h001;
        end
        // comparator has settled: take one result and power down
        if (s.phase == PH_SAMPLE && s.settle == 2'h0) begin
          next_s.phase  = PH_SLEEP;
          next_s.result = s.cmp_f;
          if (!s.cmp_f) begin
            next_s.low_run = 4'h0;
          end else if (s.low_run + 4'h1 >= need) begin
            event_low      = 1'b1;
            next_s.low_run = 4'h0;
          end else begin
            next_s.low_run = s.low_run + 4'h1;
          end
        end else if (s.phase == PH_SAMPLE) begin
          next_s.settle = s.settle - 2'h1;
        end
      end
    end

    // low event: reset when selected, flag otherwise, at the same moment
    if (event_low && s.rst_sel == RESET_SEL_CODE) begin
      next_s.rst_out = 1'b1;
    end else if (event_low) begin
      next_s.flag = 1'b1;
    end else if (wr_flag && reg_wdata[0]) begin
      // clear only without a simultaneous low event; flag holds otherwise
      next_s.flag = 1'b0;
      if (s.enable) begin
        reinit = 1'b1;
      end
    end

    // reset state: continuous mode, fields forced; source and level kept
    if (next_s.rst_out) begin
      next_s.run_mode    = MODE_CONT;
      next_s.low_cnt_sel = 2'h0;
      next_s.ie          = 1'b0;
      next_s.clk.debug_run = RST_DEBUG_RUN;
      next_s.clk.divider   = RST_CLK_DIV;
      next_s.clk.source    = RST_CLK_SRC;
      // released once a continuous compare sees recovery
      if (s.rst_out && s.phase == PH_CONT && !s.cmp_f) begin
        next_s.rst_out = 1'b0;
      end
    end

    if (reinit) begin
      next_s.phase   = PH_IDLE;
      next_s.per_cnt = 9'h000;
      next_s.low_run = 4'h0;
      next_s.fired   = 1'b0;
      next_s.settle  = 2'h0;
    end

    // outputs registered from the next state
    next_s.irq     = next_s.flag && next_s.ie;
    next_s.comp_on = next_s.phase == PH_CONT || next_s.phase == PH_SAMPLE;

    // read data stands only in the cycle after the strobe
    next_s.rdata = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_CLOCK_CTRL: next_s.rdata = {7'h00, s.clk.debug_run, 1'b0, s.clk.divider,
                                        2'h0, s.clk.source};
        OFS_CTRL:       next_s.rdata = {s.vsel, s.low_cnt_sel, s.thresh, s.rst_sel,
                                        1'b0, s.run_mode, s.enable};
        OFS_FLAG:       next_s.rdata = {7'h00, s.result, 7'h00, s.flag};
        OFS_IRQ_ENABLE: next_s.rdata = {15'h0000, s.ie};
        OFS_PROTECT:    next_s.rdata = {15'h0000, s.prot_open};
        default:        next_s.rdata = 16'h0000;
      endcase
    end
  end

  // single state register; all fields take constants under reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s             <= '0;
      s.clk.debug_run <= RST_DEBUG_RUN;
      s.clk.divider <= RST_CLK_DIV;
      s.clk.source  <= RST_CLK_SRC;
      s.phase       <= PH_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // every output straight from the state register
  assign reg_rdata            = s.rdata;
  assign comp_ctrl.power      = s.comp_on;
  assign comp_ctrl.source_sel = s.vsel;
  assign comp_ctrl.level      = s.thresh;
  assign clock_cfg            = s.clk;
  assign irq                  = s.irq;
  assign monitor_reset        = s.rst_out;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  AST_IRQ_GATE: assert property (##1 irq == $past(next_s.flag && next_s.ie))
    else $error("irq not equal to flag and enable");
  AST_FLAG_STICKY: assert property (s.flag && !(wr_flag && reg_wdata[0]) |=> s.flag)
    else $error("flag dropped without a clear");
  AST_RESULT_CONT: assert property (s.phase == PH_CONT && active && s.run_mode == MODE_CONT
    |=> s.result == $past(s.cmp_f))
    else $error("continuous result not following comparator");
  AST_RST_HOLD: assert property (s.rst_out && s.cmp_f |=> s.rst_out)
    else $error("reset released while still low");
  AST_RST_FIELDS: assert property (s.rst_out |-> s.run_mode == MODE_CONT && !s.ie
    && s.low_cnt_sel == 2'h0 && s.clk.debug_run)
    else $error("reset state fields not forced");
  AST_FLAG_SEL: assert property ($rose(s.flag) |-> $past(s.rst_sel) != RESET_SEL_CODE)
    else $error("flag set although reset selected");
  AST_PROTECT: assert property (reg_wr && reg_addr == OFS_CTRL && !s.prot_open && !s.rst_out
    |=> $stable(s.thresh) && $stable(s.vsel))
    else $error("locked write changed control");
  AST_COUNT_CONT: assert property (s.run_mode == MODE_CONT ##1 s.run_mode == MODE_CONT
    |-> $stable(s.low_cnt_sel))
    else $error("low count changed in continuous mode");
  AST_DISABLE: assert property ($fell(s.enable) |-> $past(s.disabling)
    && $past(s.dis_cnt) == 3'h0)
    else $error("enable dropped before hardware reset ended");
  AST_PERIOD: assert property (s.phase == PH_SLEEP |-> s.per_cnt <= per_last)
    else $error("period counter beyond period");
  AST_LOWRUN: assert property (!active |=> s.low_run == 4'h0)
    else $error("low counter kept while disabled");

  // read data must fall back to zero outside the answer cycle
  AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data standing without a read");

  // the prohibited top code can never reach the threshold ladder
  AST_LEVEL_LEGAL: assert property (comp_ctrl.level != LEVEL_BAD_HIGH)
    else $error("prohibited threshold code reached comparator");

  // between two detections the last result stays readable
  AST_RESULT_KEEP: assert property (s.phase == PH_SLEEP && $past(s.phase) == PH_SLEEP
    |-> $stable(s.result))
    else $error("result changed while comparator asleep");

  // comparator is powered while comparing continuously or sampling only
  AST_POWER: assert property (comp_ctrl.power
    == (s.phase == PH_CONT || s.phase == PH_SAMPLE))
    else $error("comparator power outside a detection");

  // a reset request only ever comes from a running detector
  AST_RST_ACTIVE: assert property ($rose(monitor_reset) |-> $past(active))
    else $error("reset raised while detector idle");

  // the run of low detections never reaches the count without an event
  AST_LOWRUN_MAX: assert property (s.low_run < need)
    else $error("low run reached count without event");

  // main scenarios that the bench should reach
  COV_FLAG:   cover property ($rose(s.flag));
  COV_DISABLE: cover property ($fell(s.enable));
  COV_FROZEN: cover property (debug_mode && !s.clk.debug_run && s.phase == PH_SLEEP);
  COV_RESET:  cover property ($rose(s.rst_out) ##[1:200] $fell(s.rst_out));
  COV_SAMPLE: cover property (s.phase == PH_SAMPLE ##1 s.phase == PH_SLEEP);

endmodule : supply_voltage_detector_ctrl

//--- tb/comparator_model.sv
// Purpose: behavioural comparator and threshold ladder beside the monitor
// Assumes: threshold levels step evenly from a base voltage in millivolts
// Notes:   an unpowered comparator output wanders, so stale values never look valid
`timescale 1ns/100ps
module comparator_model
  import supply_monitor_pkg::*;
#(
  parameter int BASE_MV = 1200,
  parameter int STEP_MV = 83
) (
  input  wire logic        clk_sys,
  input  wire comp_ctrl_t  comp_ctrl,
  input  wire logic [15:0] main_mv,
  input  wire logic [15:0] ext_mv,
  output      logic        comp_low
);
  int   thr;
  logic wander = 1'b0;

  // level code to millivolts; codes 0x00 and 0x1F are never programmed
  assign thr = BASE_MV + (int'(comp_ctrl.level) - 1) * STEP_MV;

  // toggles every cycle while the comparator is unpowered
  always @(posedge clk_sys) wander <= ~wander;

  // strictly below the threshold reads low; the selected source feeds it
  always_comb begin
    if (!comp_ctrl.power) comp_low = wander;
    else if (comp_ctrl.source_sel) comp_low = int'(ext_mv) < thr;
    else comp_low = int'(main_mv) < thr;
  end
endmodule : comparator_model

//--- tb/testbench.sv
// Purpose: self-checking bench of the supply monitor control block
// Assumes: detector clock near 2.3 MHz so intermittent periods stay short
// Notes:   register bus driven by tasks, comparator modelled in millivolts
`timescale 1ns/100ps
module testbench
  import supply_monitor_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        rst_n, reg_wr, reg_rd, detector_clock, debug_mode, comp_low;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, main_mv, ext_mv, d;
  comp_ctrl_t  comp_ctrl;
  clk_cfg_t    clock_cfg;
  logic        irq, monitor_reset;
  logic [31:0] seed;
  logic [4:0]  lv;
  int          errors = 0;
  int          total_checks = 0;
  int          ticks = 0;
  int          pows = 0;
  int          t0, i;

  supply_voltage_detector_ctrl #(.SETTLE_TICKS(2)) i_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .detector_clock(detector_clock), .debug_mode(debug_mode), .comp_low(comp_low),
    .comp_ctrl(comp_ctrl), .clock_cfg(clock_cfg), .irq(irq),
    .monitor_reset(monitor_reset));

  comparator_model i_cmp (.clk_sys(clk_sys), .comp_ctrl(comp_ctrl), .main_mv(main_mv),
    .ext_mv(ext_mv), .comp_low(comp_low));

  // clocks; the odd detector offset keeps its edges off the system edges
  always #25 clk_sys = ~clk_sys;
  initial begin
    detector_clock = 1'b0;
    #12.3;
    forever #213 detector_clock = ~detector_clock;
  end
  always @(posedge detector_clock) ticks <= ticks + 1;
  always @(posedge comp_ctrl.power) pows <= pows + 1;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [15:0] thr_mv(input logic [4:0] l);
    thr_mv = 16'(1200 + (int'(l) - 1) * 83);
  endfunction : thr_mv

  function automatic logic [15:0] ctrl_w(input logic vs, input logic [1:0] sc,
      input logic [4:0] th, input logic [3:0] rs, input logic [1:0] md, input logic en);
    ctrl_w = {vs, sc, th, rs, 1'b0, md, en};
  endfunction : ctrl_w

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    @(negedge clk_sys);
    v = reg_rdata;
  endtask : rd

  task automatic rdchk(input string n, input logic [3:0] a, input logic [15:0] m,
      input logic [15:0] want);
    logic [15:0] v;
    rd(a, v);
    chk(n, want, v & m);
  endtask : rdchk

  // bounded poll for a slow field, then one comparison
  task automatic poll(input string n, input logic [3:0] a, input logic [15:0] m,
      input logic [15:0] want);
    logic [15:0] v;
    for (int k = 0; k < 40; k++) begin
      rd(a, v);
      if ((v & m) === want) break;
    end
    chk(n, want, v & m);
  endtask : poll

  task automatic end_sim;
    if (errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim

  // watchdog: the whole run needs well under 80k cycles
  initial begin
    #4000000;
    errors++;
    end_sim();
  end

  initial begin
    rst_n = 1'b0; reg_addr = 4'h0; reg_wdata = 16'h0000; reg_wr = 1'b0; reg_rd = 1'b0;
    debug_mode = 1'b0; main_mv = 16'd3500; ext_mv = 16'd3500; seed = 32'hB862014F;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    chk("clock_cfg", 16'h0020, 16'(clock_cfg));
    rdchk("clock_ctrl", OFS_CLOCK_CTRL, 16'hFFFF, 16'h0100);
    rdchk("ctrl", OFS_CTRL, 16'hFFFF, 16'h0000);
    rdchk("unmapped", 4'hE, 16'hFFFF, 16'h0000);
    wr(OFS_CLOCK_CTRL, 16'h0133);
    rdchk("locked", OFS_CLOCK_CTRL, 16'hFFFF, 16'h0100);
    wr(OFS_PROTECT, PROTECT_KEY);
    rdchk("protect", OFS_PROTECT, 16'h0001, 16'h0001);
    // every clock source with a random divider code 0 to 3 and debug bit
    for (i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      d = {seed[15:2], 2'(i)} & 16'h0133;
      wr(OFS_CLOCK_CTRL, d);
      rdchk("clock_ctrl", OFS_CLOCK_CTRL, 16'hFFFF, d);
      chk("clock_cfg", {10'h000, d[8], d[6:4], d[1:0]}, 16'(clock_cfg));
    end
    // continuous mode at a random legal level; count writes ignored
    seed = lfsr(seed);
    lv = 5'(1 + seed[7:0] % 30);
    wr(OFS_IRQ_ENABLE, 16'h0001);
    wr(OFS_CTRL, ctrl_w(0, 2'h3, lv, 4'h0, MODE_CONT, 1));
    rdchk("ctrl", OFS_CTRL, 16'hFFFF, ctrl_w(0, 2'h0, lv, 4'h0, MODE_CONT, 1));
    main_mv <= thr_mv(lv);
    repeat (20) @(posedge clk_sys);
    rdchk("at threshold", OFS_FLAG, 16'h0101, 16'h0000);
    main_mv <= thr_mv(lv) - 16'd1;
    poll("below", OFS_FLAG, 16'h0101, 16'h0101);
    chk("irq", 16'h0001, 16'(irq));
    main_mv <= 16'd3500;
    poll("recovered", OFS_FLAG, 16'h0101, 16'h0001);
    wr(OFS_IRQ_ENABLE, 16'h0000);
    repeat (2) @(negedge clk_sys);
    chk("irq masked", 16'h0000, 16'(irq));
    wr(OFS_FLAG, 16'h0001);
    rdchk("cleared", OFS_FLAG, 16'h0001, 16'h0000);
    wr(OFS_CTRL, ctrl_w(0, 2'h0, LEVEL_BAD_LOW, 4'h0, MODE_CONT, 1));
    wr(OFS_CTRL, ctrl_w(0, 2'h0, LEVEL_BAD_HIGH, 4'h0, MODE_CONT, 1));
    rdchk("bad level", OFS_CTRL, 16'h1F00, 16'(lv) << 8);
    // external pin low while the main supply stays high
    wr(OFS_CTRL, ctrl_w(1, 2'h0, lv, 4'h0, MODE_CONT, 1));
    ext_mv <= thr_mv(lv) - 16'd1;
    poll("external", OFS_FLAG, 16'h0100, 16'h0100);
    chk("source_sel", 16'h0001, 16'(comp_ctrl.source_sel));
    ext_mv <= 16'd3500;
    poll("external high", OFS_FLAG, 16'h0100, 16'h0000);
    // intermittent ticks freeze in debug mode when the run bit is clear
    wr(OFS_CLOCK_CTRL, 16'h0000);
    debug_mode <= 1'b1;
    wr(OFS_CTRL, ctrl_w(0, 2'h0, lv, 4'h0, 2'h1, 1));
    t0 = pows;
    repeat (300) @(posedge detector_clock);
    chk("frozen", 16'(t0), 16'(pows));
    debug_mode <= 1'b0;
    wr(OFS_CLOCK_CTRL, 16'h0100);
    // period of each intermittent mode in detector ticks
    for (i = 1; i < 4; i++) begin
      wr(OFS_CTRL, ctrl_w(0, 2'h0, lv, 4'h0, 2'(i), 1));
      @(posedge comp_ctrl.power);
      t0 = ticks;
      @(posedge comp_ctrl.power);
      chk("period", 16'(128 << (i - 1)), 16'(ticks - t0));
    end
    // consecutive low detections needed for each count code
    for (i = 0; i < 4; i++) begin
      main_mv <= 16'd3500;
      wr(OFS_FLAG, 16'h0001);
      wr(OFS_CTRL, ctrl_w(0, 2'(i), lv, 4'h0, 2'h1, 1));
      main_mv <= thr_mv(lv) - 16'd1;
      repeat ((1 << i) - 1) @(negedge comp_ctrl.power);
      repeat (4) @(negedge clk_sys);
      rdchk("flag early", OFS_FLAG, 16'h0001, 16'h0000);
      @(negedge comp_ctrl.power);
      repeat (4) @(negedge clk_sys);
      rdchk("flag", OFS_FLAG, 16'h0001, 16'h0001);
    end
    // reset issuance from intermittent mode, then recovery
    main_mv <= 16'd3500;
    wr(OFS_FLAG, 16'h0001);
    wr(OFS_CLOCK_CTRL, 16'h0033);
    wr(OFS_IRQ_ENABLE, 16'h0001);
    wr(OFS_CTRL, ctrl_w(0, 2'h1, lv, RESET_SEL_CODE, 2'h1, 1));
    main_mv <= thr_mv(lv) - 16'd1;
    repeat (2) @(negedge comp_ctrl.power);
    repeat (4) @(negedge clk_sys);
    chk("reset", 16'h0001, 16'(monitor_reset));
    rdchk("ctrl held", OFS_CTRL, 16'hFFFF, ctrl_w(0, 0, lv, RESET_SEL_CODE, 0, 1));
    rdchk("clock held", OFS_CLOCK_CTRL, 16'hFFFF, 16'h0100);
    rdchk("ie held", OFS_IRQ_ENABLE, 16'h0001, 16'h0000);
    rdchk("flag held", OFS_FLAG, 16'h0101, 16'h0100);
    chk("powered", 16'h0001, 16'(comp_ctrl.power));
    main_mv <= 16'd3500;
    repeat (20) @(negedge clk_sys);
    chk("released", 16'h0000, 16'(monitor_reset));
    // disable takes a few cycles, then protection closes again
    wr(OFS_CTRL, ctrl_w(0, 2'h0, lv, 4'h0, 2'h0, 0));
    rdchk("disabling", OFS_CTRL, 16'h0001, 16'h0001);
    poll("disabled", OFS_CTRL, 16'h0001, 16'h0000);
    wr(OFS_PROTECT, 16'h0000);
    wr(OFS_CTRL, 16'h0001);
    rdchk("relocked", OFS_CTRL, 16'h0001, 16'h0000);
    end_sim();
  end
endmodule : testbench
